// ---- rtl/mie_execute.sv ----
// Instruction execute unit of an 8-bit microcontroller core with an APB status port
`timescale 1ns/1ps
`include "mie_params.svh"

module mie_execute #(
  parameter int PCW = 12
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                opValid,
  input  wire mie_pkg::mie_op_type opCode,
  input  wire logic [7:0]          opAddr,
  input  wire logic [2:0]          opBit,
  input  wire logic [7:0]          opImm,
  input  wire logic [PCW-1:0]      opTarget,
  output logic                     opReady,
  input  wire logic [7:0]          memRdData,
  output logic                     memWrEn,
  output logic [7:0]               memWrAddr,
  output logic [7:0]               memWrData,
  output logic                     stackPush,
  output logic [PCW-1:0]           stackPushData,
  output logic                     stackPop,
  input  wire logic [PCW-1:0]      stackTop,
  input  wire logic                irqRequest,
  input  wire logic                wdtTimeout,
  input  wire logic                wakeUp,
  output logic                     wdtClear,
  output logic                     prescalerClear,
  output logic                     clockGate,
  output logic [PCW-1:0]           pc,
  output logic [7:0]               workingRegister,
  output logic                     carryFlag,
  output logic                     halfCarryFlag,
  output logic                     zeroFlag,
  output logic                     overflowFlag,
  output logic                     watchdogTimeoutFlag,
  output logic                     powerdownFlag,
  output logic                     globalIrqEnable,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr
);
  import mie_pkg::*;

  // ----------------------------------------------------------------
  // Operand and result datapath
  // ----------------------------------------------------------------
  mie_state_type state;
  mie_state_type next_state;
  mie_pre_type   prePending;
  mie_pre_type   next_pre;
  logic          runEnable;

  wire           take     = opValid & opReady;
  wire           irqEnter = (state == ST_RUN) & ~opReady & globalIrqEnable & irqRequest;
  wire           useImm   = (opCode == OP_ADD_I) | (opCode == OP_AND_I) | (opCode == OP_OR_I);
  wire [7:0]     operandB = useImm ? opImm : memRdData;
  wire           addCin   = ((opCode == OP_ADC_M) | (opCode == OP_ADCM)) & carryFlag;
  wire [8:0]     addSum   = {1'b0, workingRegister} + {1'b0, operandB} + {8'h00, addCin};
  wire [4:0]     addHalf  = {1'b0, workingRegister[3:0]} + {1'b0, operandB[3:0]}
                            + {4'h0, addCin};
  wire           addOvf   = (workingRegister[7] == operandB[7])
                            & (addSum[7] != workingRegister[7]);
  wire [7:0]     resAnd   = workingRegister & operandB;
  wire [7:0]     resOr    = workingRegister | operandB;
  wire [7:0]     resInv   = ~memRdData;
  wire [7:0]     resDec   = memRdData - 8'h01;
  wire [7:0]     resInc   = memRdData + 8'h01;
  wire [7:0]     resBitClr = memRdData & ~(8'h01 << opBit);
  wire [7:0]     resRl    = {memRdData[6:0], memRdData[7]};
  wire           adjLow   = (workingRegister[3:0] > 4'h9) | halfCarryFlag;
  wire           adjHigh  = (workingRegister[7:4] > 4'h9) | carryFlag;
  wire [8:0]     adjSum   = {1'b0, workingRegister}
                            + {1'b0, adjHigh ? 4'h6 : 4'h0, adjLow ? 4'h6 : 4'h0};
  wire [PCW-1:0] pcInc    = pc + {{(PCW-1){1'b0}}, 1'b1};

  logic [7:0]     next_wreg;
  logic [7:0]     next_memData;
  logic [PCW-1:0] next_pc;
  logic [PCW-1:0] next_pushData;
  logic           next_memWe, next_push, next_pop, next_wdtClr, next_presClr;
  logic           next_c, next_h, next_z, next_v, next_to, next_pd, next_gie;

  // ----------------------------------------------------------------
  // Instruction execution
  // ----------------------------------------------------------------
  always_comb begin
    next_state    = state;
    next_pre      = prePending;
    next_wreg     = workingRegister;
    next_memData  = 8'h00;
    next_memWe    = 1'b0;
    next_pc       = pc;
    next_pushData = stackPushData;
    next_push     = 1'b0;
    next_pop      = 1'b0;
    next_wdtClr   = 1'b0;
    next_presClr  = 1'b0;
    next_c        = carryFlag;
    next_h        = halfCarryFlag;
    next_z        = zeroFlag;
    next_v        = overflowFlag;
    next_to       = watchdogTimeoutFlag;
    next_pd       = powerdownFlag;
    next_gie      = globalIrqEnable;
    if (state == ST_HALTED) begin
      if (wakeUp | wdtTimeout) begin
        next_state = ST_RUN;
      end
    end else if (state == ST_DUMMY) begin
      next_state = ST_RUN;
    end else if (take) begin
      next_pc = pcInc;
      case (opCode)
        OP_ADD_M, OP_ADD_I, OP_ADC_M, OP_ADDM, OP_ADCM: begin
          if ((opCode == OP_ADDM) | (opCode == OP_ADCM)) begin
            next_memWe   = 1'b1;
            next_memData = addSum[7:0];
          end else begin
            next_wreg = addSum[7:0];
          end
          next_c = addSum[8];
          next_h = addHalf[4];
          next_v = addOvf;
          next_z = (addSum[7:0] == 8'h00);
        end
        OP_AND_M, OP_AND_I: begin
          next_wreg = resAnd;
          next_z    = (resAnd == 8'h00);
        end
        OP_ANDM: begin
          next_memWe   = 1'b1;
          next_memData = resAnd;
          next_z       = (resAnd == 8'h00);
        end
        OP_OR_M, OP_OR_I: begin
          next_wreg = resOr;
          next_z    = (resOr == 8'h00);
        end
        OP_ORM: begin
          next_memWe   = 1'b1;
          next_memData = resOr;
          next_z       = (resOr == 8'h00);
        end
        OP_INV, OP_INVA: begin
          if (opCode == OP_INV) begin
            next_memWe   = 1'b1;
            next_memData = resInv;
          end else begin
            next_wreg = resInv;
          end
          next_z = (resInv == 8'h00);
        end
        OP_DECADJ: begin
          next_memWe   = 1'b1;
          next_memData = adjSum[7:0];
          next_c       = adjHigh | adjSum[8];
        end
        OP_DEC, OP_DECA: begin
          if (opCode == OP_DEC) begin
            next_memWe   = 1'b1;
            next_memData = resDec;
          end else begin
            next_wreg = resDec;
          end
          next_z = (resDec == 8'h00);
        end
        OP_INC, OP_INCA: begin
          if (opCode == OP_INC) begin
            next_memWe   = 1'b1;
            next_memData = resInc;
          end else begin
            next_wreg = resInc;
          end
          next_z = (resInc == 8'h00);
        end
        OP_CLR: begin
          next_memWe   = 1'b1;
          next_memData = 8'h00;
        end
        OP_CLRBIT: begin
          next_memWe   = 1'b1;
          next_memData = resBitClr;
        end
        OP_WDCLR: begin
          next_wdtClr = 1'b1;
          next_to     = 1'b0;
          next_pd     = 1'b0;
        end
        OP_PRE_FIRST, OP_PRE_SECOND: begin
          // Another instruction in between does not break a pending pair
          if ((opCode == OP_PRE_FIRST && prePending == PRE_SECOND)
              || (opCode == OP_PRE_SECOND && prePending == PRE_FIRST)) begin
            next_wdtClr = 1'b1;
            next_to     = 1'b0;
            next_pd     = 1'b0;
            next_pre    = PRE_NONE;
          end else begin
            next_pre = (opCode == OP_PRE_FIRST) ? PRE_FIRST : PRE_SECOND;
          end
        end
        OP_HALT: begin
          next_wdtClr  = 1'b1;
          next_presClr = 1'b1;
          next_to      = 1'b0;
          next_pd      = 1'b1;
          next_state   = ST_HALTED;
        end
        OP_CALL: begin
          next_push     = 1'b1;
          next_pushData = pcInc;
          next_pc       = opTarget;
          next_state    = ST_DUMMY;
        end
        OP_JMP: begin
          next_pc    = opTarget;
          next_state = ST_DUMMY;
        end
        OP_MOV_WM: next_wreg = memRdData;
        OP_MOV_WI: next_wreg = opImm;
        OP_MOV_MW: begin
          next_memWe   = 1'b1;
          next_memData = workingRegister;
        end
        OP_RET, OP_RET_IMM, OP_IRQRET: begin
          next_pop   = 1'b1;
          next_pc    = stackTop;
          next_state = ST_DUMMY;
          if (opCode == OP_RET_IMM) begin
            next_wreg = opImm;
          end
          if (opCode == OP_IRQRET) begin
            next_gie = 1'b1;
          end
        end
        OP_RL: begin
          next_memWe   = 1'b1;
          next_memData = resRl;
        end
        OP_RLA: next_wreg = resRl;
        default: ;
      endcase
      // A store to the counter's low byte redirects the fetch
      if (next_memWe && opAddr == `MIE_PC_LOW_ADDR) begin
        next_pc[7:0] = next_memData;
        next_state   = ST_DUMMY;
      end
    end else if (irqEnter) begin
      // Pending request is served here, also right after an interrupt return
      next_push     = 1'b1;
      next_pushData = pc;
      next_pc       = PCW'(`MIE_IRQ_VECTOR);
      next_gie      = 1'b0;
      next_state    = ST_DUMMY;
    end
    if (wdtTimeout) begin
      next_to = 1'b1;
    end
  end

  // Ready is predicted from this cycle's request so an interrupt gets a free slot
  wire next_ready = (next_state == ST_RUN) & runEnable & ~(irqRequest & next_gie);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RUN;
      prePending <= PRE_NONE;
      opReady <= 1'b0;
      workingRegister <= 8'h00;
      pc <= '0;
      {carryFlag, halfCarryFlag, zeroFlag, overflowFlag} <= 4'h0;
      {watchdogTimeoutFlag, powerdownFlag, globalIrqEnable} <= 3'h0;
    end else begin
      state <= next_state;
      prePending <= next_pre;
      opReady <= next_ready;
      workingRegister <= next_wreg;
      pc <= next_pc;
      {carryFlag, halfCarryFlag, zeroFlag, overflowFlag} <= {next_c, next_h, next_z, next_v};
      {watchdogTimeoutFlag, powerdownFlag, globalIrqEnable} <= {next_to, next_pd, next_gie};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {memWrEn, stackPush, stackPop, wdtClear, prescalerClear, clockGate} <= 6'h00;
      memWrAddr <= 8'h00;
      memWrData <= 8'h00;
      stackPushData <= '0;
    end else begin
      {memWrEn, stackPush, stackPop} <= {next_memWe, next_push, next_pop};
      {wdtClear, prescalerClear} <= {next_wdtClr, next_presClr};
      clockGate <= (next_state == ST_HALTED);
      memWrAddr <= opAddr;
      memWrData <= next_memData;
      stackPushData <= next_pushData;
    end
  end

  // ----------------------------------------------------------------
  // APB slave, one wait-free access cycle
  // ----------------------------------------------------------------
  wire        hitStatus  = (paddr == `MIE_STATUS_OFFSET);
  wire        hitControl = (paddr == `MIE_CONTROL_OFFSET);
  wire        apbSetup   = psel & ~penable;
  wire        ctrlWrite  = psel & penable & pready & pwrite & hitControl;
  wire        halted     = (state == ST_HALTED);
  wire [31:0] statusWord = {{(16 - PCW){1'b0}}, pc, halted, globalIrqEnable,
                            powerdownFlag, watchdogTimeoutFlag, overflowFlag,
                            zeroFlag, halfCarryFlag, carryFlag, workingRegister};
  wire [31:0] readWord   = hitStatus ? statusWord :
                           hitControl ? {31'h0, runEnable} : 32'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      runEnable <= `MIE_CONTROL_RESET;
    end else begin
      pready <= apbSetup;
      pslverr <= apbSetup & (~(hitStatus | hitControl) | (pwrite & hitStatus));
      prdata <= (apbSetup & ~pwrite) ? readWord : 32'h0;
      if (ctrlWrite) begin
        runEnable <= pwdata[`MIE_CT_RUN];
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_taken(mie_op_type o);
    take && opCode == o;
  endsequence
  sequence s_dummy;
    !opReady && state == ST_DUMMY;
  endsequence

  a_call_push: assert property (s_taken(OP_CALL) |=> stackPush
    && stackPushData == $past(pcInc) && pc == $past(opTarget) ##0 s_dummy)
    else $error("call did not push return address");
  a_jump_dummy: assert property (s_taken(OP_JMP) |=> s_dummy ##0 pc == $past(opTarget))
    else $error("jump without dummy cycle");
  a_clear_byte: assert property (s_taken(OP_CLR) ##0 opAddr != `MIE_PC_LOW_ADDR
    |=> memWrEn && memWrData == 8'h00 && $stable(zeroFlag) && $stable(carryFlag))
    else $error("clear byte wrong");
  a_bit_clear: assert property (s_taken(OP_CLRBIT)
    |=> memWrEn && memWrData == ($past(memRdData) & ~(8'h01 << $past(opBit))))
    else $error("bit clear wrong");
  a_pair_clear: assert property (s_taken(OP_PRE_SECOND) ##0 (prePending == PRE_FIRST
    && !wdtTimeout) |=> wdtClear && !watchdogTimeoutFlag && !powerdownFlag)
    else $error("pre-clear pair did not clear");
  a_repeat_none: assert property (s_taken(OP_PRE_FIRST) ##0 prePending != PRE_SECOND
    |=> !wdtClear && powerdownFlag == $past(powerdownFlag))
    else $error("repeated pre-clear had effect");
  a_halt_entry: assert property (s_taken(OP_HALT) ##0 !wdtTimeout
    |=> clockGate && powerdownFlag && !watchdogTimeoutFlag && wdtClear && prescalerClear)
    else $error("halt entry wrong");
  a_add_imm: assert property (s_taken(OP_ADD_I)
    |=> workingRegister == $past(addSum[7:0]) && carryFlag == $past(addSum[8]))
    else $error("add immediate wrong");
  a_and_zero: assert property (s_taken(OP_AND_I) |=> zeroFlag == ($past(resAnd) == 8'h00)
    && $stable(carryFlag) && $stable(overflowFlag))
    else $error("and flags wrong");
  a_irq_return: assert property (s_taken(OP_IRQRET) |=> globalIrqEnable && stackPop)
    else $error("interrupt return wrong");
  a_rotate_reg: assert property (s_taken(OP_RLA)
    |=> !memWrEn && workingRegister == {$past(memRdData[6:0]), $past(memRdData[7])})
    else $error("rotate to register wrong");

endmodule

// ---- rtl/mie_params.svh ----
// Register offsets, field positions and reset values of the execute block
`ifndef MIE_PARAMS_SVH
`define MIE_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define MIE_STATUS_OFFSET   32'h0000_0000
`define MIE_CONTROL_OFFSET  32'h0000_0004

// ----------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------
`define MIE_ST_WREG_LSB     0
`define MIE_ST_CARRY        8
`define MIE_ST_HALF         9
`define MIE_ST_ZERO         10
`define MIE_ST_OVF          11
`define MIE_ST_TIMEOUT      12
`define MIE_ST_PDOWN        13
`define MIE_ST_GIE          14
`define MIE_ST_HALTED       15
`define MIE_ST_PC_LSB       16

// ----------------------------------------------------------------
// Control field position and reset value, PC low byte address and interrupt vector
// ----------------------------------------------------------------
`define MIE_CT_RUN          0
`define MIE_CONTROL_RESET   1'b1
`define MIE_PC_LOW_ADDR     8'h06
`define MIE_IRQ_VECTOR      16'h0004

`endif

// ---- rtl/mie_pkg.sv ----
// Types shared by the execute block
package mie_pkg;

  typedef enum logic [5:0] {
    OP_NOP, OP_ADD_M, OP_ADDM, OP_ADD_I, OP_ADC_M, OP_ADCM,
    OP_AND_M, OP_ANDM, OP_AND_I, OP_OR_M, OP_ORM, OP_OR_I,
    OP_INV, OP_INVA, OP_DECADJ, OP_DEC, OP_DECA, OP_INC, OP_INCA,
    OP_CLR, OP_CLRBIT, OP_WDCLR, OP_PRE_FIRST, OP_PRE_SECOND,
    OP_HALT, OP_CALL, OP_JMP, OP_MOV_WM, OP_MOV_WI, OP_MOV_MW,
    OP_RET, OP_RET_IMM, OP_IRQRET, OP_RL, OP_RLA
  } mie_op_type;

  typedef enum logic [1:0] {ST_RUN, ST_DUMMY, ST_HALTED} mie_state_type;

  typedef enum logic [1:0] {PRE_NONE, PRE_FIRST, PRE_SECOND} mie_pre_type;

endpackage

// ---- verif/mie_partner.sv ----
// Data memory and return stack facing the execute unit
`timescale 1ns/1ps
module mie_partner #(
  parameter int PCW = 12
) (
  input  wire logic           clk,
  input  wire logic [7:0]     rdAddr,
  output logic [7:0]          rdData,
  input  wire logic           wrEn,
  input  wire logic [7:0]     wrAddr,
  input  wire logic [7:0]     wrData,
  input  wire logic           push,
  input  wire logic [PCW-1:0] pushData,
  input  wire logic           pop,
  output logic [PCW-1:0]      top
);
  logic [7:0]     mem [256];
  logic [PCW-1:0] stk [8];
  logic [PCW-1:0] noise = '0;
  int             depth = 0;

  assign rdData = mem[rdAddr];
  // Empty stack shows a moving pattern, so a stray pop cannot look right
  assign top = (depth > 0) ? stk[depth-1] : noise;

  always @(posedge clk) begin
    noise <= noise + 'h5a3;
    if (wrEn)
      mem[wrAddr] <= wrData;
    if (push && depth < 8) begin
      stk[depth] <= pushData;
      depth <= depth + 1;
    end
    if (pop && depth > 0)
      depth <= depth - 1;
  end
endmodule

// ---- verif/mie_execute_tb.sv ----
// Self-checking bench of the execute unit against a reference model
`timescale 1ns/1ps
module mie_execute_tb;
  import mie_pkg::*;
  localparam int PCW = 12;
  logic clk, rst_n, opValid, opReady, memWrEn, stackPush, stackPop, irqRequest, wdtTimeout;
  logic wakeUp, wdtClear, prescalerClear, clockGate, carryFlag, halfCarryFlag, zeroFlag;
  logic overflowFlag, watchdogTimeoutFlag, powerdownFlag, globalIrqEnable;
  logic psel, penable, pwrite, pready, pslverr;
  mie_op_type     opCode;
  logic [7:0]     opAddr, opImm, memRdData, memWrAddr, memWrData, workingRegister;
  logic [2:0]     opBit;
  logic [PCW-1:0] opTarget, stackPushData, stackTop, pc;
  logic [31:0]    paddr, pwdata, prdata;
  logic [32:0]    res;
  int acc, c, hc, z, ov, to, pd, gie, cg, pcm, pend, ePush, ePop, eWc, ePc, pushExp;
  int n_errors, comparisons, cyc, i, k;
  int seed = 30178;
  int mm [256];
  int stk [$];
  mie_op_type alu [26] = '{OP_NOP, OP_ADD_M, OP_ADDM, OP_ADD_I, OP_ADC_M, OP_ADCM, OP_AND_M,
    OP_ANDM, OP_AND_I, OP_OR_M, OP_ORM, OP_OR_I, OP_INV, OP_INVA, OP_DECADJ, OP_DEC, OP_DECA,
    OP_INC, OP_INCA, OP_CLR, OP_CLRBIT, OP_MOV_WM, OP_MOV_WI, OP_MOV_MW, OP_RL, OP_RLA};

  mie_execute #(.PCW(PCW)) i_mie_execute (.clk, .rst_n, .opValid, .opCode, .opAddr, .opBit,
    .opImm, .opTarget, .opReady, .memRdData, .memWrEn, .memWrAddr, .memWrData, .stackPush,
    .stackPushData, .stackPop, .stackTop, .irqRequest, .wdtTimeout, .wakeUp, .wdtClear,
    .prescalerClear, .clockGate, .pc, .workingRegister, .carryFlag, .halfCarryFlag, .zeroFlag,
    .overflowFlag, .watchdogTimeoutFlag, .powerdownFlag, .globalIrqEnable, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

  mie_partner #(.PCW(PCW)) i_mie_partner (.clk, .rdAddr(opAddr), .rdData(memRdData),
    .wrEn(memWrEn), .wrAddr(memWrAddr), .wrData(memWrData), .push(stackPush),
    .pushData(stackPushData), .pop(stackPop), .top(stackTop));

  // --------------------------------------------------------------
  // Clock, hang guard and reporting
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic test_done();
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic compare(logic [32:0] got, logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_state();
    compare({pc, workingRegister, carryFlag, halfCarryFlag, zeroFlag, overflowFlag,
      watchdogTimeoutFlag, powerdownFlag, globalIrqEnable, clockGate, stackPush, stackPop,
      wdtClear, prescalerClear}, {pcm[11:0], acc[7:0], c[0], hc[0], z[0], ov[0], to[0],
      pd[0], gie[0], cg[0], ePush[0], ePop[0], eWc[0], ePc[0]});
    ePush = 0;
    ePop = 0;
    eWc = 0;
    ePc = 0;
  endtask

  // --------------------------------------------------------------
  // Instruction driver with the reference model
  // --------------------------------------------------------------
  task automatic issue(mie_op_type o, int a, int x, int t = 0, int b = 0);
    int m, r, s, ci, lo, hi;
    bit wm, two;
    m = mm[a];
    r = -1;
    wm = o inside {OP_ADDM, OP_ADCM, OP_ANDM, OP_ORM, OP_INV, OP_DECADJ, OP_DEC, OP_INC,
      OP_CLR, OP_CLRBIT, OP_MOV_MW, OP_RL};
    two = (o inside {OP_CALL, OP_JMP, OP_RET, OP_RET_IMM, OP_IRQRET}) || (wm && a == 6);
    @(posedge clk);
    opCode <= o;
    opAddr <= a[7:0];
    opImm <= x[7:0];
    opTarget <= t[PCW-1:0];
    opBit <= b[2:0];
    opValid <= 1'b1;
    do @(posedge clk); while (opReady !== 1'b1);
    opValid <= 1'b0;
    pcm = (pcm + 1) % 4096;
    case (o)
      OP_ADD_M, OP_ADDM, OP_ADD_I, OP_ADC_M, OP_ADCM: begin
        s = (o == OP_ADD_I) ? x : m;
        ci = (o inside {OP_ADC_M, OP_ADCM}) ? c : 0;
        hc = ((acc & 15) + (s & 15) + ci) > 15;
        r = acc + s + ci;
        ov = ((acc ^ r) & (s ^ r) & 128) != 0;
        c = r > 255;
        r = r & 255;
        z = r == 0;
      end
      OP_AND_M, OP_ANDM, OP_AND_I: r = acc & ((o == OP_AND_I) ? x : m);
      OP_OR_M, OP_ORM, OP_OR_I: r = acc | ((o == OP_OR_I) ? x : m);
      OP_INV, OP_INVA: r = ~m & 255;
      OP_DEC, OP_DECA: r = (m + 255) & 255;
      OP_INC, OP_INCA: r = (m + 1) & 255;
      OP_DECADJ: begin
        lo = (acc & 15) > 9 || hc;
        hi = (acc >> 4) > 9 || c;
        r = acc + 6 * lo + 96 * hi;
        c = hi || r > 255;
        r = r & 255;
      end
      OP_CLR: r = 0;
      OP_CLRBIT: r = m & ~(1 << b);
      OP_RL, OP_RLA: r = ((m << 1) | (m >> 7)) & 255;
      OP_MOV_WM: r = m;
      OP_MOV_WI: r = x;
      OP_MOV_MW: r = acc;
      OP_WDCLR, OP_HALT: begin
        to = 0;
        pd = (o == OP_HALT);
        eWc = 1;
        ePc = (o == OP_HALT);
        cg = (o == OP_HALT);
      end
      OP_PRE_FIRST, OP_PRE_SECOND: begin
        s = (o == OP_PRE_FIRST) ? 1 : 2;
        // Only the partner half completes the pair; a repeat stays pending
        if (pend != 0 && pend != s) begin
          to = 0;
          pd = 0;
          eWc = 1;
          pend = 0;
        end else
          pend = s;
      end
      OP_CALL: begin
        pushExp = pcm;
        stk.push_back(pcm);
        pcm = t;
        ePush = 1;
      end
      OP_JMP: pcm = t;
      OP_RET, OP_RET_IMM, OP_IRQRET: begin
        pcm = stk.pop_back();
        ePop = 1;
        if (o == OP_RET_IMM)
          acc = x;
        if (o == OP_IRQRET)
          gie = 1;
      end
      default: ;
    endcase
    if (r >= 0 && wm) begin
      mm[a] = r;
      if (a == 6)
        pcm = (pcm & 'hf00) | r;
    end else if (r >= 0)
      acc = r;
    if (o inside {OP_AND_M, OP_ANDM, OP_AND_I, OP_OR_M, OP_ORM, OP_OR_I, OP_INV, OP_INVA,
        OP_DEC, OP_DECA, OP_INC, OP_INCA})
      z = r == 0;
    @(negedge clk);
    compare(opReady, !(two || o == OP_HALT));
    compare(wm ? {memWrEn, memWrAddr, memWrData} : memWrEn,
      wm ? {1'b1, a[7:0], r[7:0]} : 0);
    if (ePush)
      compare(stackPushData, pushExp);
    check_state();
  endtask

  // Wake from halt, or raise the timeout while running
  task automatic wake(bit byTimeout);
    @(posedge clk);
    wdtTimeout <= byTimeout;
    wakeUp <= !byTimeout;
    @(posedge clk);
    wdtTimeout <= 1'b0;
    wakeUp <= 1'b0;
    cg = 0;
    to = to | byTimeout;
    do @(negedge clk); while (opReady !== 1'b1);
    check_state();
  endtask

  task automatic apb(bit wr, logic [31:0] ad, logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    res = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    {opValid, irqRequest, wdtTimeout, wakeUp, psel, penable, pwrite} = '0;
    opCode = OP_NOP;
    {opAddr, opImm, opBit, opTarget, paddr, pwdata} = '0;
    rst_n = 1'b0;
    for (i = 0; i < 256; i++) begin
      mm[i] = $random(seed) & 255;
      i_mie_partner.mem[i] = mm[i];
    end
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check_state();
    for (i = 0; i < 300; i++) begin
      k = $unsigned($random(seed)) % 26;
      issue(alu[k], 16 + $unsigned($random(seed)) % 32, $random(seed) & 255, 0, i % 8);
    end
    issue(OP_MOV_WI, 0, 'h35);
    issue(OP_MOV_MW, 6, 0);
    issue(OP_JMP, 0, 0, 'h2f0);
    issue(OP_CALL, 0, 0, 'h123);
    issue(OP_RET_IMM, 0, 'h5a);
    issue(OP_CALL, 0, 0, 'h0e0);
    issue(OP_RET, 0, 0);
    issue(OP_CALL, 0, 0, 'h200);
    issue(OP_IRQRET, 0, 0);
    @(posedge clk);
    irqRequest <= 1'b1;
    do @(negedge clk); while (globalIrqEnable !== 1'b0);
    pushExp = pcm;
    stk.push_back(pcm);
    pcm = 4;
    gie = 0;
    ePush = 1;
    compare(stackPushData, pushExp);
    check_state();
    @(posedge clk);
    irqRequest <= 1'b0;
    issue(OP_IRQRET, 0, 0);
    issue(OP_HALT, 0, 0);
    wake(1'b1);
    issue(OP_PRE_FIRST, 0, 0);
    issue(OP_PRE_FIRST, 0, 0);
    issue(OP_NOP, 0, 0);
    issue(OP_PRE_SECOND, 0, 0);
    issue(OP_HALT, 0, 0);
    wake(1'b0);
    wake(1'b1);
    issue(OP_WDCLR, 0, 0);
    apb(1'b1, 'h4, 0);
    compare(res, 0);
    apb(1'b0, 'h4, 0);
    compare(res, 0);
    @(negedge clk);
    compare(opReady, 0);
    apb(1'b1, 'h4, 1);
    apb(1'b0, 'h0, 0);
    compare(res, {5'h0, pcm[11:0], cg[0], gie[0], pd[0], to[0], ov[0], z[0], hc[0], c[0],
      acc[7:0]});
    apb(1'b0, 'h8, 0);
    compare(res, 33'h1_0000_0000);
    apb(1'b1, 'h0, 'hffff);
    compare(res, 33'h1_0000_0000);
    test_done();
  end
endmodule
